// ### src/qdc_dac_end.sv
// Purpose: Converter-side 2-wire slave with double-buffered channel registers
// Assumes: Link wires and strobe pins arrive asynchronously to core_clk
// Notes: out_enable low means the output stages are open-circuit
// Function
// RULE_01 - Write opens with address, write bit, acked
// RULE_02 - Pointer byte follows address, acked
// RULE_03 - Two data bytes then stop end write
// RULE_04 - Repeated start, read address, two bytes sent
// RULE_05 - Master ack repeats same two bytes forever
// RULE_06 - Bare read uses previously stored pointer
// RULE_07 - Input register loads only on complete write
// RULE_08 - Strobe high holds DAC registers
// RULE_09 - Strobe low makes DAC registers follow inputs
// RULE_10 - Only freshly written channels update
// RULE_11 - Gain and buffer bits double-buffered too
// RULE_12 - Synchronous mode updates after eighth clock edge
// RULE_13 - Asynchronous mode updates on strobe falling
// RULE_14 - Power-down by pin low or bit zero
// RULE_15 - Normal only with pin high and bit one
// RULE_16 - Power-down leaves outputs open-circuit
// RULE_17 - Registers keep working through power-down
// RULE_18 - Outputs resume from DAC registers at once
// RULE_19 - Word: control bits high, code right-justified
// RULE_20 - Pointer selects one of four channels
// RULE_21 - Clear bit zeroes every channel code
module qdc_dac_end (
  input wire logic core_clk,
  input wire logic resetn,
  qdc_link_if.dev link,
  input wire logic load_strobe_n,
  input wire logic power_down_n,
  output logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CODE_W-1:0] dac_code,
  output logic [qdc_pkg::NUM_CH-1:0] dac_gain,
  output logic [qdc_pkg::NUM_CH-1:0] dac_buf,
  output logic out_enable
);
  import qdc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} qdc_state_type;

  function automatic logic [PTR_CH_W-1:0] chan_of(input logic [7:0] ptr);
    chan_of = ptr[PTR_CH_LSB +: PTR_CH_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and line events
  logic [3:0] pins_s;
  qdc_pin_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in({link.scl, link.sda, load_strobe_n, power_down_n}),
    .pin_out(pins_s)
  );
  wire scl_s = pins_s[3];
  wire sda_s = pins_s[2];
  wire strobe_n_s = pins_s[1];
  wire pd_pin_n_s = pins_s[0];

  logic scl_p_q;
  logic sda_p_q;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state
  qdc_state_type state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] byte_q;
  logic rw_q;
  logic ack_on_q;
  logic rd_lo_q;
  logic sda_oe_q;
  logic [7:0] ptr_q;
  logic [7:0] hi_q;
  logic pd_bit_q;
  logic out_en_q;

  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  wire byte_end = (state_q == ST_RX) & scl_rise & (cnt_q == 4'h7);
  wire addr_hit = rx_byte[7:1] == DEV_ADDR;
  // Eighth rising edge of the low data byte of a write
  wire commit = byte_end & (byte_q == BY_LO) & ~rw_q; // RULE_07
  wire [15:0] wr_word = {hi_q, rx_byte};
  wire clr_req = commit & wr_word[CLR_BIT];
  wire [PTR_CH_W-1:0] wr_ch = chan_of(ptr_q);

  logic [CODE_W-1:0] in_code_q [NUM_CH];
  logic in_gain_q [NUM_CH];
  logic in_buf_q [NUM_CH];

  // Readback shows the input register of the pointed channel
  wire [PTR_CH_W-1:0] rd_ch = chan_of(ptr_q); // RULE_20
  wire [15:0] rd_word = {in_gain_q[rd_ch], in_buf_q[rd_ch], 1'b0, pd_bit_q,
    in_code_q[rd_ch]}; // RULE_19
  wire [7:0] cur_byte = rd_lo_q ? rd_word[7:0] : rd_word[15:8];
  wire tx_bit = cur_byte[~cnt_q[2:0]];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      byte_q <= BY_ADDR;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      rd_lo_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ptr_q <= 8'h00;
      hi_q <= 8'h00;
    end else if (start_det) begin
      // Also serves a repeated start
      state_q <= ST_RX; // RULE_04
      byte_q <= BY_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE; // RULE_03
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= rx_byte;
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_end) begin
            ack_on_q <= 1'b0;
            state_q <= ST_ACK;
            case (byte_q)
              BY_ADDR: begin
                rw_q <= rx_byte[0]; // RULE_01
                if (!addr_hit) begin
                  state_q <= ST_IDLE;
                end
              end
              BY_PTR: ptr_q <= rx_byte; // RULE_02
              BY_HI: hi_q <= rx_byte; // RULE_03
              default: ;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall && !ack_on_q) begin
            sda_oe_q <= 1'b1; // RULE_01 RULE_02
            ack_on_q <= 1'b1;
          end else if (scl_fall) begin
            ack_on_q <= 1'b0;
            if (byte_q == BY_ADDR && rw_q) begin
              // Pointer kept from earlier transaction
              state_q <= ST_TX; // RULE_06
              rd_lo_q <= 1'b0;
              sda_oe_q <= ~rd_word[15];
              cnt_q <= 4'h1;
            end else if (byte_q == BY_LO) begin
              state_q <= ST_IDLE;
              sda_oe_q <= 1'b0;
            end else begin
              state_q <= ST_RX;
              byte_q <= byte_q + 2'h1;
              cnt_q <= 4'h0;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall && cnt_q == 4'h8) begin
            sda_oe_q <= 1'b0;
            state_q <= ST_MACK;
          end else if (scl_fall) begin
            sda_oe_q <= ~tx_bit; // RULE_04
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_MACK: begin
          if (scl_rise && !sda_s) begin
            // Alternate high and low bytes while the master acks
            rd_lo_q <= ~rd_lo_q; // RULE_05
            cnt_q <= 4'h0;
            state_q <= ST_TX;
          end else if (scl_rise) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers
  logic [CODE_W-1:0] dac_code_q [NUM_CH];
  logic dac_gain_q [NUM_CH];
  logic dac_buf_q [NUM_CH];
  logic pend_q [NUM_CH];

  genvar g;
  for (g = 0; g < NUM_CH; g++) begin : g_ch
    wire sel = commit & (wr_ch == PTR_CH_W'(g));
    wire touch = sel | clr_req;
    // Strobe low level: covers tied-low sync mode and falling-edge async mode
    wire xfer = ~strobe_n_s & pend_q[g]; // RULE_09 RULE_12 RULE_13

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        in_code_q[g] <= CODE_RST;
        in_gain_q[g] <= 1'b0;
        in_buf_q[g] <= 1'b0;
      end else begin
        if (touch) begin
          in_code_q[g] <= clr_req ? CODE_RST : wr_word[CODE_MSB:0]; // RULE_21
        end
        if (sel) begin
          in_gain_q[g] <= wr_word[GAIN_BIT];
          in_buf_q[g] <= wr_word[BUF_BIT];
        end
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pend_q[g] <= 1'b0;
      end else if (touch) begin
        // A new write wins over a transfer in the same cycle
        pend_q[g] <= 1'b1; // RULE_10
      end else if (xfer) begin
        pend_q[g] <= 1'b0;
      end
    end

    // Strobe high or nothing pending: hold
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        dac_code_q[g] <= CODE_RST;
        dac_gain_q[g] <= 1'b0;
        dac_buf_q[g] <= 1'b0;
      end else if (xfer) begin // RULE_08 RULE_10
        dac_code_q[g] <= in_code_q[g];
        dac_gain_q[g] <= in_gain_q[g]; // RULE_11
        dac_buf_q[g] <= in_buf_q[g]; // RULE_11
      end
    end

    assign dac_code[g] = dac_code_q[g];
    assign dac_gain[g] = dac_gain_q[g];
    assign dac_buf[g] = dac_buf_q[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down; registers above are never gated by it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pd_bit_q <= PD_BIT_RST;
      out_en_q <= 1'b0;
    end else begin
      if (commit) begin
        pd_bit_q <= wr_word[PD_BIT]; // RULE_14 RULE_17
      end
      out_en_q <= pd_pin_n_s & pd_bit_q; // RULE_15 RULE_16 RULE_18
    end
  end

  assign out_enable = out_en_q;
  assign link.sda_oe_dev = sda_oe_q;
  assign link.sda_o_dev = 1'b0;
endmodule // qdc_dac_end

// ### src/qdc_host_end.sv
// Purpose: 2-wire master that writes and reads back converter channels
// Assumes: One command at a time; line clock from a core_clk divider
// Notes: Reads ack the first byte and nack the second
module qdc_host_end (
  input wire logic core_clk,
  input wire logic resetn,
  qdc_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_ptr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_nack
);
  import qdc_pkg::*;

  typedef enum logic [2:0] {OP_START, OP_TX, OP_RXA, OP_RXN, OP_STOP} qdc_op_type;

  // Step list of each command kind
  function automatic logic [10:0] op_at(input logic [1:0] kind, input logic [2:0] idx,
      input logic [7:0] ptr, input logic [15:0] data);
    logic [7:0] aw;
    logic [7:0] ar;
    aw = {DEV_ADDR, 1'b0}; // RULE_01
    ar = {DEV_ADDR, 1'b1}; // RULE_04
    op_at = {OP_STOP, 8'h00};
    if (kind == CMD_WRITE) begin
      case (idx)
        3'h0: op_at = {OP_START, 8'h00};
        3'h1: op_at = {OP_TX, aw};
        3'h2: op_at = {OP_TX, ptr}; // RULE_02
        3'h3: op_at = {OP_TX, data[15:8]}; // RULE_03 RULE_19
        3'h4: op_at = {OP_TX, data[7:0]};
        default: op_at = {OP_STOP, 8'h00};
      endcase
    end else if (kind == CMD_READ_PTR) begin
      case (idx)
        3'h0: op_at = {OP_START, 8'h00};
        3'h1: op_at = {OP_TX, aw};
        3'h2: op_at = {OP_TX, ptr};
        3'h3: op_at = {OP_START, 8'h00};
        3'h4: op_at = {OP_TX, ar};
        3'h5: op_at = {OP_RXA, 8'h00};
        3'h6: op_at = {OP_RXN, 8'h00};
        default: op_at = {OP_STOP, 8'h00};
      endcase
    end else begin
      case (idx)
        3'h0: op_at = {OP_START, 8'h00};
        3'h1: op_at = {OP_TX, ar};
        3'h2: op_at = {OP_RXA, 8'h00};
        3'h3: op_at = {OP_RXN, 8'h00};
        default: op_at = {OP_STOP, 8'h00};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic sda_s;
  qdc_pin_sync #(.W(1)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in(link.sda),
    .pin_out(sda_s)
  );

  logic busy_q;
  logic abort_q;
  logic [1:0] kind_q;
  logic [7:0] ptr_q;
  logic [15:0] data_q;
  logic [2:0] idx_q;
  logic [3:0] bit_q;
  logic [1:0] qtr_q;
  logic [QTR_W-1:0] div_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic [15:0] rx_q;
  logic rdy_q;
  logic rv_q;
  logic [15:0] rd_q;
  logic rn_q;

  wire [10:0] cur = op_at(kind_q, idx_q, ptr_q, data_q);
  wire [2:0] op = abort_q ? 3'(OP_STOP) : cur[10:8];
  wire [7:0] ob = cur[7:0];
  wire tick = busy_q & (div_q == QTR_W'(QTR_CYC - 1));
  wire is_tx = op == 3'(OP_TX);
  wire is_rx = (op == 3'(OP_RXA)) | (op == 3'(OP_RXN));
  wire last_bit = bit_q == 4'h8;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick | ~busy_q ? '0 : div_q + QTR_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      abort_q <= 1'b0;
      kind_q <= CMD_WRITE;
      ptr_q <= 8'h00;
      data_q <= 16'h0000;
      idx_q <= 3'h0;
      bit_q <= 4'h0;
      qtr_q <= 2'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rx_q <= 16'h0000;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= 16'h0000;
      rn_q <= 1'b0;
    end else begin
      rv_q <= 1'b0;
      rdy_q <= ~busy_q & ~(cmd_valid & rdy_q);
      if (!busy_q && cmd_valid && rdy_q) begin
        busy_q <= 1'b1;
        abort_q <= 1'b0;
        kind_q <= cmd_kind;
        ptr_q <= cmd_ptr;
        data_q <= cmd_data;
        idx_q <= 3'h0;
        bit_q <= 4'h0;
        qtr_q <= 2'h0;
      end else if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        case (qtr_q)
          2'h0: begin
            if (op == 3'(OP_START)) begin
              sda_oe_q <= 1'b0;
            end else if (op == 3'(OP_STOP)) begin
              sda_oe_q <= 1'b1;
            end else if (is_tx) begin
              sda_oe_q <= ~last_bit & ~ob[~bit_q[2:0]];
            end else begin
              sda_oe_q <= last_bit & (op == 3'(OP_RXA));
            end
          end
          2'h1: scl_oe_q <= 1'b0;
          2'h2: begin
            if (op == 3'(OP_START)) begin
              sda_oe_q <= 1'b1;
            end else if (op == 3'(OP_STOP)) begin
              sda_oe_q <= 1'b0;
            end else if (is_tx && last_bit && sda_s) begin
              abort_q <= 1'b1;
            end else if (is_rx && !last_bit) begin
              rx_q <= {rx_q[14:0], sda_s};
            end
          end
          default: begin
            // A nacked byte first ends its ack clock, then a full stop runs
            if (op == 3'(OP_STOP) && !last_bit) begin
              busy_q <= 1'b0;
              rv_q <= 1'b1;
              rd_q <= rx_q;
              rn_q <= abort_q;
            end else begin
              scl_oe_q <= 1'b1;
              if (op == 3'(OP_START) || last_bit) begin
                bit_q <= 4'h0;
                idx_q <= idx_q + 3'h1;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  assign cmd_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign rsp_nack = rn_q;
  assign link.scl_oe_host = scl_oe_q;
  assign link.scl_o_host = 1'b0;
  assign link.sda_oe_host = sda_oe_q;
  assign link.sda_o_host = 1'b0;
endmodule // qdc_host_end

// ### src/qdc_link_if.sv
// Purpose: Open-drain 2-wire link between host end and converter end
// Assumes: Pull-ups on both wires; enable high pulls the wire low
// Notes: Only the host drives the clock wire
interface qdc_link_if;
  logic scl_oe_host;
  logic scl_o_host;
  logic sda_oe_host;
  logic sda_o_host;
  logic sda_oe_dev;
  logic sda_o_dev;
  wire scl;
  wire sda;
  assign scl = ~(scl_oe_host & ~scl_o_host);
  assign sda = ~((sda_oe_host & ~sda_o_host) | (sda_oe_dev & ~sda_o_dev));
  modport dev (input scl, input sda, output sda_oe_dev, output sda_o_dev);
  modport host (input sda, output scl_oe_host, output scl_o_host,
    output sda_oe_host, output sda_o_host);
endinterface // qdc_link_if

// ### src/qdc_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs idle high
// Notes: Output moves only when stages two and three agree
module qdc_pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        s1_q[g] <= 1'b1;
        s2_q[g] <= 1'b1;
        s3_q[g] <= 1'b1;
        out_q[g] <= 1'b1;
      end else begin
        s1_q[g] <= pin_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          out_q[g] <= s3_q[g];
        end
      end
    end
  end
  assign pin_out = out_q;
endmodule // qdc_pin_sync

// ### src/qdc_pkg.sv
// Purpose: Shared constants for the quad converter 2-wire control ends
// Assumes: 12-bit code width, four channels, 100 MHz core clock
// Notes: Data word layout is gain, buffer, clear, power-down, then code
package qdc_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 12;
  // Slave address; both ends must agree on it
  localparam logic [6:0] DEV_ADDR = 7'h0C;
  // Data word fields
  localparam int GAIN_BIT = 15;
  localparam int BUF_BIT = 14;
  localparam int CLR_BIT = 13;
  localparam int PD_BIT = 12;
  localparam int CODE_MSB = 11;
  // Pointer field that picks the channel
  localparam int PTR_CH_LSB = 0;
  localparam int PTR_CH_W = 2;
  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic PD_BIT_RST = 1'b1;
  // Byte positions inside a write
  localparam logic [1:0] BY_ADDR = 2'h0;
  localparam logic [1:0] BY_PTR = 2'h1;
  localparam logic [1:0] BY_HI = 2'h2;
  localparam logic [1:0] BY_LO = 2'h3;
  // Host command kinds
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ_PTR = 2'h1;
  localparam logic [1:0] CMD_READ_CUR = 2'h2;
  // Host line timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_W = 9;
endpackage // qdc_pkg

// ### tb/qdc_link_asserts.sv
// Purpose: Wire and output checks beside the link joining both ends
// Assumes: Strobe and power-down pins pass a three-stage synchroniser plus an agreement-filter flop
// Notes: Lag bounds allow a few cycles of synchroniser delay
module qdc_link_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_oe_dev,
  input wire logic load_strobe_n,
  input wire logic power_down_n,
  input wire logic [qdc_pkg::NUM_CH-1:0][qdc_pkg::CODE_W-1:0] dac_code,
  input wire logic out_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import qdc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the strobe pin was last low, saturating
  logic [3:0] lo_age_q;
  logic [3:0] lo_age_d;
  logic lo_age_max;
  assign lo_age_max = (lo_age_q == 4'hF);
  assign lo_age_d = !load_strobe_n ? 4'h0 : (lo_age_max ? lo_age_q : lo_age_q + 4'h1);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) lo_age_q <= 4'hF;
    else lo_age_q <= lo_age_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Device may only move SDA while SCL is low, else it fakes start or stop
  property p_ack_at_scl_low; $rose(sda_oe_dev) |-> !scl; endproperty
  a_ack_at_scl_low: assert property (p_ack_at_scl_low)
    else $error("device pulled SDA while SCL high");
  property p_release_at_scl_low; $fell(sda_oe_dev) |-> !scl; endproperty
  a_release_at_scl_low: assert property (p_release_at_scl_low)
    else $error("device released SDA while SCL high");
  property p_ack_held; $rose(sda_oe_dev) |-> sda_oe_dev [*8]; endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("device SDA pull too short");
  property p_dac_held; load_strobe_n [*8] |=> $stable(dac_code); endproperty
  a_dac_held: assert property (p_dac_held)
    else $error("DAC register moved with strobe high");
  property p_dac_needs_strobe; $changed(dac_code) |-> lo_age_q < 4'h9; endproperty
  a_dac_needs_strobe: assert property (p_dac_needs_strobe)
    else $error("DAC register moved without recent strobe");
  property p_pd_pin; !power_down_n [*8] |-> !out_enable; endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("outputs enabled with power-down pin low");
  property p_wake_pin; $rose(out_enable) |-> $past(power_down_n, 4); endproperty
  a_wake_pin: assert property (p_wake_pin)
    else $error("outputs woke without power-down pin high");
  property p_pd_keeps_regs; $fell(out_enable) |-> $stable(dac_code); endproperty
  a_pd_keeps_regs: assert property (p_pd_keeps_regs)
    else $error("DAC register moved on power-down entry");
endmodule // qdc_link_asserts

// ### tb/tb_top.sv
// Purpose: Host end drives the converter end over the shared link
// Assumes: 400 kHz line clock from the host, so each write is ~9.5k cycles
// Notes: Six transfers keep the run near 60k cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qdc_pkg::*;
  logic core_clk;
  logic resetn;
  logic load_strobe_n;
  logic power_down_n;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
  logic [NUM_CH-1:0] dac_gain;
  logic [NUM_CH-1:0] dac_buf;
  logic out_enable;
  logic cmd_valid;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_ptr;
  logic [15:0] cmd_data;
  logic cmd_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic rsp_nack;
  logic [15:0] rd;
  logic nack;
  int fails = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  qdc_link_if link();
  qdc_dac_end u_qdc_dac_end (.core_clk(core_clk), .resetn(resetn), .link(link),
    .load_strobe_n(load_strobe_n), .power_down_n(power_down_n), .dac_code(dac_code),
    .dac_gain(dac_gain), .dac_buf(dac_buf), .out_enable(out_enable));
  qdc_host_end u_qdc_host_end (.core_clk(core_clk), .resetn(resetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  qdc_link_asserts u_qdc_link_asserts (.core_clk(core_clk), .resetn(resetn), .scl(link.scl),
    .sda_oe_dev(link.sda_oe_dev), .load_strobe_n(load_strobe_n),
    .power_down_n(power_down_n), .dac_code(dac_code), .out_enable(out_enable));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until the edge that sees cmd_ready high
  task automatic host_cmd(input logic [1:0] kind, input logic [7:0] ptr,
      input logic [15:0] data);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      cycles(1);
      n++;
    end
    cmd_kind = kind;
    cmd_ptr = ptr;
    cmd_data = data;
    cmd_valid = 1'b1;
    cycles(1);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60000) begin
      cycles(1);
      n++;
    end
    if (rsp_valid !== 1'b1) fails++;
    rd = rsp_data;
    nack = rsp_nack;
    cycles(2);
  endtask
  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Limit allows six transfers plus margin
  initial begin
    #900_000;
    fails++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    load_strobe_n = 1'b1;
    power_down_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = CMD_WRITE;
    cmd_ptr = 8'h00;
    cmd_data = 16'h0000;
    cycles(16);
    chk("reset code", 16'h0000, {4'h0, dac_code[2]});
    chk("reset oe", 16'h0000, {15'h0, out_enable});
    resetn = 1'b1;
    cycles(20);
    chk("oe after reset", 16'h0001, {15'h0, out_enable});
    // Strobe high: input register only; upper pointer bits ignored
    host_cmd(CMD_WRITE, 8'hFE, 16'h9A5C);
    chk("write nack", 16'h0000, {15'h0, nack});
    chk("ch2 before strobe", 16'h0000, {4'h0, dac_code[2]});
    load_strobe_n = 1'b0;
    cycles(8);
    load_strobe_n = 1'b1;
    cycles(8);
    chk("ch2 code", 16'h0A5C, {4'h0, dac_code[2]});
    chk("ch2 gain buf", 16'h0002, {14'h0, dac_gain[2], dac_buf[2]});
    chk("ch1 untouched", 16'h0000, {4'h0, dac_code[1]});
    // Bare read reuses the stored pointer
    host_cmd(CMD_READ_CUR, 8'h00, 16'h0000);
    chk("readback", 16'h9A5C, rd);
    chk("read nack", 16'h0000, {15'h0, nack});
    power_down_n = 1'b0;
    cycles(10);
    chk("oe pin down", 16'h0000, {15'h0, out_enable});
    chk("ch2 in pd", 16'h0A5C, {4'h0, dac_code[2]});
    power_down_n = 1'b1;
    cycles(10);
    chk("oe pin up", 16'h0001, {15'h0, out_enable});
    // Strobe tied low: update follows the write
    load_strobe_n = 1'b0;
    cycles(8);
    host_cmd(CMD_WRITE, 8'h00, 16'h5123);
    chk("ch0 code", 16'h0123, {4'h0, dac_code[0]});
    chk("ch0 gain buf", 16'h0001, {14'h0, dac_gain[0], dac_buf[0]});
    chk("oe pd bit one", 16'h0001, {15'h0, out_enable});
    chk("ch2 kept", 16'h0A5C, {4'h0, dac_code[2]});
    // Strobe high again; this write clears the power-down bit
    load_strobe_n = 1'b1;
    cycles(8);
    host_cmd(CMD_WRITE, 8'h01, 16'hC456);
    chk("oe pd bit", 16'h0000, {15'h0, out_enable});
    chk("ch1 held", 16'h0000, {4'h0, dac_code[1]});
    // Strobe pulse during power-down still loads
    load_strobe_n = 1'b0;
    cycles(8);
    load_strobe_n = 1'b1;
    cycles(8);
    chk("ch1 in pd", 16'h0456, {4'h0, dac_code[1]});
    chk("ch1 gain buf", 16'h0003, {14'h0, dac_gain[1], dac_buf[1]});
    chk("oe still pd", 16'h0000, {15'h0, out_enable});
    // Pointer then repeated start; bit 12 reads the global power-down bit
    host_cmd(CMD_READ_PTR, 8'h02, 16'h0000);
    chk("readback ptr", 16'h8A5C, rd);
    chk("read ptr nack", 16'h0000, {15'h0, nack});
    // Clear with power-down bit back to one, strobe low
    load_strobe_n = 1'b0;
    cycles(8);
    host_cmd(CMD_WRITE, 8'h03, 16'h3FFF);
    chk("ch1 cleared", 16'h0000, {4'h0, dac_code[1]});
    chk("ch2 cleared", 16'h0000, {4'h0, dac_code[2]});
    chk("oe pd bit up", 16'h0001, {15'h0, out_enable});
    end_sim;
  end
endmodule // tb_top
